//--- rtl/router_defines.svh
// offsets, field positions, reset values and widths for the channel mode router
`ifndef ROUTER_DEFINES_SVH
`define ROUTER_DEFINES_SVH

// apb byte addresses
`define ADDR_W 12
`define CTRL_OFFSET 12'h000
`define STATUS_OFFSET 12'h004
`define PINS_OFFSET 12'h008

// control register fields (selector bit = 1 means parallel position)
`define CTRL_W 9
`define CTRL_SEL_DATA 0
`define CTRL_SEL_LATCH 1
`define CTRL_SEL_SHIFT 2
`define CTRL_SEL_GATE 3
`define CTRL_LINK_LO 4
`define CTRL_LINK_HI 7
`define CTRL_LINK_FOURTH 8
`define CTRL_RESET 9'h100

// header pin vector positions
`define PIN_SEL_A 0
`define PIN_SEL_B 1
`define PIN_SEL_C 2
`define PIN_AUX_FOURTH 3
`define PIN_AUX_LO 4
`define PIN_AUX_HI 7

// reset values
`define BYTE_RESET 8'h00
`define PHASE_IDLE 8'hFF
`define WORD_RESET 32'h0000_0000

`endif

//--- rtl/router_pkg.sv
// types shared by the channel mode router
`default_nettype none
package router_pkg;

   typedef struct packed {
      logic [7:0] s1_ff;
      logic [7:0] s2_ff;
      logic [7:0] s3_ff;
      logic [7:0] filt_ff;
      logic [8:0] ctrl_ff;
      logic [7:0] shift_ff;
      logic [7:0] store_ff;
      logic [7:0] drive_ff;
      logic [3:0] lamp_ff;
      logic [7:0] phase_ff;
      logic ser_ff;
      logic rclk_ff;
      logic shift_clock_in_ff;
      logic gate_n_ff;
      logic contend_ff;
      logic pready_ff;
      logic pslverr_ff;
      logic [31:0] prdata_ff;
   } router_state_t;

endpackage

`default_nettype wire

//--- rtl/stepper_channel_mode_router.sv
// channel mode router: header pins to eight sink channels via serial or parallel path
//
// Behaviour
// - serial selector a routes hdr_sel_a to shift data
// - parallel selector a drives channel one directly
// - serial selector b routes hdr_sel_b to latch clock
// - parallel selector b drives channel two directly
// - serial selector c routes hdr_sel_c to shift clock
// - parallel selector c drives channel three directly
// - gate selector: serial enables, parallel disables outputs
// - shift outputs or host lines drive channels one-four
// - lamps one-four follow their drive inputs
// - high drive one pulls phase one low
// - high drives two-four pull phases two-four low
// - fourth aux line feeds channel four through resistor
// - other aux lines unconnected unless links fitted
// - all eight channels serial or parallel controllable
// - linked aux lines drive channels five to eight
//
// Design decisions made here: the APB register port and the register offsets.
`timescale 1ns/1ps
`default_nettype none
`include "router_defines.svh"

module stepper_channel_mode_router
   import router_pkg::*;
(
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // apb slave
   input wire logic psel,
   input wire logic penable,
   input wire logic pwrite,
   input wire logic [11:0] paddr,
   input wire logic [31:0] pwdata,
   output logic [31:0] prdata,
   output logic pready,
   output logic pslverr,
   // header pins from the host
   input wire logic hdr_sel_a,
   input wire logic hdr_sel_b,
   input wire logic hdr_sel_c,
   input wire logic hdr_aux_fourth,
   input wire logic hdr_aux_line_a,
   input wire logic hdr_aux_line_b,
   input wire logic hdr_aux_line_c,
   input wire logic hdr_aux_line_d,
   // shift register input nodes
   output logic shift_data_in,
   output logic shift_clock_in,
   output logic latch_clock_in,
   output logic output_gate_n,
   // channel drive inputs
   output logic drive_input_1,
   output logic drive_input_2,
   output logic drive_input_3,
   output logic drive_input_4,
   output logic drive_input_5,
   output logic drive_input_6,
   output logic drive_input_7,
   output logic drive_input_8,
   // indicator lamps
   output logic indicator_lamp_1,
   output logic indicator_lamp_2,
   output logic indicator_lamp_3,
   output logic indicator_lamp_4,
   // sink outputs, low means pulled to ground
   output logic motor_a_phase_1,
   output logic motor_a_phase_2,
   output logic motor_a_phase_3,
   output logic motor_a_phase_4,
   output logic motor_b_phase_1,
   output logic motor_b_phase_2,
   output logic motor_b_phase_3,
   output logic motor_b_phase_4
);

   router_state_t st_ff;
   router_state_t nxt_st;

   logic [7:0] pin_raw;
   logic [7:0] filt;
   logic [3:0] sel_par;
   logic [7:0] host_en;
   logic [7:0] host_lvl;
   wire logic [7:0] drv;
   logic sr_on;
   logic setup_phase;
   logic access_done;

   assign pin_raw = {hdr_aux_line_d, hdr_aux_line_c, hdr_aux_line_b, hdr_aux_line_a,
                     hdr_aux_fourth, hdr_sel_c, hdr_sel_b, hdr_sel_a};
   assign filt = st_ff.filt_ff;
   assign sel_par = st_ff.ctrl_ff[3:0];
   assign sr_on = ~st_ff.gate_n_ff;
   assign setup_phase = psel & ~penable;
   assign access_done = psel & penable & st_ff.pready_ff;

   // host lines that reach a channel input, and their levels
   assign host_en = {st_ff.ctrl_ff[`CTRL_LINK_HI:`CTRL_LINK_LO],
                     st_ff.ctrl_ff[`CTRL_LINK_FOURTH],
                     sel_par[`CTRL_SEL_SHIFT],
                     sel_par[`CTRL_SEL_LATCH],
                     sel_par[`CTRL_SEL_DATA]};
   assign host_lvl = filt;

   // one selector per channel input; only channel four sits behind a series resistor
   // channel 1: hdr_sel_a with selector a parallel
   channel_select #(
      .SERIES_FED(1'b0)
   ) ch_1 (
      .host_en(host_en[0]),
      .host_lvl(host_lvl[0]),
      .shift_on(sr_on),
      .store_bit(st_ff.store_ff[0]),
      .drive_bit(drv[0])
   );

   // channel 2: hdr_sel_b with selector b parallel
   channel_select #(
      .SERIES_FED(1'b0)
   ) ch_2 (
      .host_en(host_en[1]),
      .host_lvl(host_lvl[1]),
      .shift_on(sr_on),
      .store_bit(st_ff.store_ff[1]),
      .drive_bit(drv[1])
   );

   // channel 3: hdr_sel_c with selector c parallel
   channel_select #(
      .SERIES_FED(1'b0)
   ) ch_3 (
      .host_en(host_en[2]),
      .host_lvl(host_lvl[2]),
      .shift_on(sr_on),
      .store_bit(st_ff.store_ff[2]),
      .drive_bit(drv[2])
   );

   // channel 4: fourth aux line, overridden while the shift outputs drive
   channel_select #(
      .SERIES_FED(1'b1)
   ) ch_4 (
      .host_en(host_en[3]),
      .host_lvl(host_lvl[3]),
      .shift_on(sr_on),
      .store_bit(st_ff.store_ff[3]),
      .drive_bit(drv[3])
   );

   // channel 5: aux line a once its link is fitted
   channel_select #(
      .SERIES_FED(1'b0)
   ) ch_5 (
      .host_en(host_en[4]),
      .host_lvl(host_lvl[4]),
      .shift_on(sr_on),
      .store_bit(st_ff.store_ff[4]),
      .drive_bit(drv[4])
   );

   // channel 6: aux line b once its link is fitted
   channel_select #(
      .SERIES_FED(1'b0)
   ) ch_6 (
      .host_en(host_en[5]),
      .host_lvl(host_lvl[5]),
      .shift_on(sr_on),
      .store_bit(st_ff.store_ff[5]),
      .drive_bit(drv[5])
   );

   // channel 7: aux line c once its link is fitted
   channel_select #(
      .SERIES_FED(1'b0)
   ) ch_7 (
      .host_en(host_en[6]),
      .host_lvl(host_lvl[6]),
      .shift_on(sr_on),
      .store_bit(st_ff.store_ff[6]),
      .drive_bit(drv[6])
   );

   // channel 8: aux line d once its link is fitted
   channel_select #(
      .SERIES_FED(1'b0)
   ) ch_8 (
      .host_en(host_en[7]),
      .host_lvl(host_lvl[7]),
      .shift_on(sr_on),
      .store_bit(st_ff.store_ff[7]),
      .drive_bit(drv[7])
   );

   always_comb begin
      nxt_st = st_ff;

      // three stage pin sampling; a bit changes only when stages two and three agree
      nxt_st.s1_ff = pin_raw;
      nxt_st.s2_ff = st_ff.s1_ff;
      nxt_st.s3_ff = st_ff.s2_ff;
      nxt_st.filt_ff = (st_ff.s2_ff & st_ff.s3_ff) |
                       (st_ff.filt_ff & (st_ff.s2_ff | st_ff.s3_ff));

      // serial routing; a line in the parallel position leaves its node low
      nxt_st.ser_ff = ~sel_par[`CTRL_SEL_DATA] & filt[`PIN_SEL_A];
      nxt_st.rclk_ff = ~sel_par[`CTRL_SEL_LATCH] & filt[`PIN_SEL_B];
      nxt_st.shift_clock_in_ff = ~sel_par[`CTRL_SEL_SHIFT] & filt[`PIN_SEL_C];
      nxt_st.gate_n_ff = sel_par[`CTRL_SEL_GATE];

      // data and clock pass the same sampling depth, so the host must set data up
      // before raising the shift clock
      if (nxt_st.shift_clock_in_ff & ~st_ff.shift_clock_in_ff) begin
         nxt_st.shift_ff = {st_ff.shift_ff[6:0], nxt_st.ser_ff};
      end
      if (nxt_st.rclk_ff & ~st_ff.rclk_ff) begin
         nxt_st.store_ff = st_ff.shift_ff;
      end

      // channel stage
      nxt_st.drive_ff = drv;
      nxt_st.lamp_ff = drv[3:0];
      nxt_st.phase_ff = ~drv;
      nxt_st.contend_ff = sr_on &
                          (|(host_en & ~(8'h01 << `PIN_AUX_FOURTH)));

      // apb: answer in the first access cycle
      nxt_st.pready_ff = 1'b0;
      if (setup_phase) begin
         nxt_st.pready_ff = 1'b1;
         nxt_st.pslverr_ff = 1'b0;
         case (paddr)
            `CTRL_OFFSET: begin
               nxt_st.prdata_ff = {23'h000000, st_ff.ctrl_ff};
            end
            `STATUS_OFFSET: begin
               nxt_st.prdata_ff = {7'h00, st_ff.contend_ff, st_ff.shift_ff,
                                   st_ff.store_ff, st_ff.drive_ff};
            end
            `PINS_OFFSET: begin
               nxt_st.prdata_ff = {24'h000000, st_ff.filt_ff};
            end
            default: begin
               nxt_st.prdata_ff = `WORD_RESET;
               nxt_st.pslverr_ff = 1'b1;
            end
         endcase
      end
      if (access_done & pwrite & (paddr == `CTRL_OFFSET)) begin
         // links for aux lines a-d default open, fourth link default fitted
         nxt_st.ctrl_ff = pwdata[`CTRL_W-1:0];
      end
      if (access_done) begin
         nxt_st.pslverr_ff = 1'b0;
      end

      if (sys_rst) begin
         nxt_st.s1_ff = `BYTE_RESET;
         nxt_st.s2_ff = `BYTE_RESET;
         nxt_st.s3_ff = `BYTE_RESET;
         nxt_st.filt_ff = `BYTE_RESET;
         nxt_st.ctrl_ff = `CTRL_RESET;
         nxt_st.shift_ff = `BYTE_RESET;
         nxt_st.store_ff = `BYTE_RESET;
         nxt_st.drive_ff = `BYTE_RESET;
         nxt_st.lamp_ff = 4'h0;
         nxt_st.phase_ff = `PHASE_IDLE;
         nxt_st.ser_ff = 1'b0;
         nxt_st.rclk_ff = 1'b0;
         nxt_st.shift_clock_in_ff = 1'b0;
         nxt_st.gate_n_ff = 1'b0;
         nxt_st.contend_ff = 1'b0;
         nxt_st.pready_ff = 1'b0;
         nxt_st.pslverr_ff = 1'b0;
         nxt_st.prdata_ff = `WORD_RESET;
      end
   end

   always_ff @(posedge clk) begin
      st_ff <= nxt_st;
   end

   assign prdata = st_ff.prdata_ff;
   assign pready = st_ff.pready_ff;
   assign pslverr = st_ff.pslverr_ff;

   assign shift_data_in = st_ff.ser_ff;
   assign shift_clock_in = st_ff.shift_clock_in_ff;
   assign latch_clock_in = st_ff.rclk_ff;
   assign output_gate_n = st_ff.gate_n_ff;

   assign drive_input_1 = st_ff.drive_ff[0];
   assign drive_input_2 = st_ff.drive_ff[1];
   assign drive_input_3 = st_ff.drive_ff[2];
   assign drive_input_4 = st_ff.drive_ff[3];
   assign drive_input_5 = st_ff.drive_ff[4];
   assign drive_input_6 = st_ff.drive_ff[5];
   assign drive_input_7 = st_ff.drive_ff[6];
   assign drive_input_8 = st_ff.drive_ff[7];

   assign indicator_lamp_1 = st_ff.lamp_ff[0];
   assign indicator_lamp_2 = st_ff.lamp_ff[1];
   assign indicator_lamp_3 = st_ff.lamp_ff[2];
   assign indicator_lamp_4 = st_ff.lamp_ff[3];

   // inverted sink outputs
   assign motor_a_phase_1 = st_ff.phase_ff[0];
   assign motor_a_phase_2 = st_ff.phase_ff[1];
   assign motor_a_phase_3 = st_ff.phase_ff[2];
   assign motor_a_phase_4 = st_ff.phase_ff[3];
   assign motor_b_phase_1 = st_ff.phase_ff[4];
   assign motor_b_phase_2 = st_ff.phase_ff[5];
   assign motor_b_phase_3 = st_ff.phase_ff[6];
   assign motor_b_phase_4 = st_ff.phase_ff[7];

endmodule // stepper_channel_mode_router

// per-channel input selector: host line, shift output or floating low
module channel_select #(
   parameter bit SERIES_FED = 1'b0
) (
   // routing state
   input wire logic host_en,
   input wire logic host_lvl,
   input wire logic shift_on,
   input wire logic store_bit,
   // channel input
   output logic drive_bit
);

   always_comb begin
      if (SERIES_FED) begin
         // series resistor: the shift output overrides the fourth aux line
         drive_bit = shift_on ? store_bit : (host_en & host_lvl);
      end else if (host_en) begin
         // a host line that is wired through wins over a contending shift output
         drive_bit = host_lvl;
      end else begin
         // a floating input is taken as low
         drive_bit = shift_on & store_bit;
      end
   end

endmodule // channel_select

`default_nettype wire

//--- test/host_gpio_model.sv
// host board model driving the eight header lines
`timescale 1ns/1ps
`default_nettype none
module host_gpio_model (
   // clock
   input wire logic clk,
   // {aux d, c, b, a, fourth, sel_c, sel_b, sel_a}
   output logic [7:0] pins
);
   initial pins = 8'h00;
   // each level held well past the pin filter, short pulses may be lost
   task automatic put(input logic [7:0] v);
      @(posedge clk);
      pins <= v;
      repeat (8) @(posedge clk);
   endtask
   // msb first so bit 7 lands in channel eight, then one latch pulse
   task automatic send(input logic [7:0] b);
      for (int i = 7; i >= 0; i--) begin
         put({pins[7:3], 2'b00, b[i]});
         put({pins[7:3], 2'b10, b[i]});
      end
      put({pins[7:3], 3'b000});
      put({pins[7:3], 3'b010});
      put({pins[7:3], 3'b000});
   endtask
endmodule // host_gpio_model
`default_nettype wire

//--- test/router_chk.sv
// port checker for the channel mode router
`timescale 1ns/1ps
`default_nettype none
module router_chk (
   // clock and reset
   input wire logic clk,
   input wire logic sys_rst,
   // bus answer
   input wire logic pready,
   input wire logic pslverr,
   // header lines
   input wire logic hdr_sel_a,
   input wire logic hdr_sel_b,
   input wire logic hdr_sel_c,
   // routed nodes
   input wire logic shift_data_in,
   input wire logic shift_clock_in,
   input wire logic latch_clock_in,
   // channel inputs
   input wire logic drive_input_1,
   input wire logic drive_input_2,
   input wire logic drive_input_3,
   input wire logic drive_input_4,
   input wire logic drive_input_5,
   input wire logic drive_input_6,
   input wire logic drive_input_7,
   input wire logic drive_input_8,
   // lamps
   input wire logic indicator_lamp_1,
   input wire logic indicator_lamp_2,
   input wire logic indicator_lamp_3,
   input wire logic indicator_lamp_4,
   // sink outputs
   input wire logic motor_a_phase_1,
   input wire logic motor_a_phase_2,
   input wire logic motor_a_phase_3,
   input wire logic motor_a_phase_4,
   input wire logic motor_b_phase_1,
   input wire logic motor_b_phase_2,
   input wire logic motor_b_phase_3,
   input wire logic motor_b_phase_4
);
   default clocking @(posedge clk); endclocking
   default disable iff (sys_rst);
   // a routed node lags its pin by the filter and one flop
   data_route_a: assert property (
      $rose(shift_data_in) |-> $past(hdr_sel_a, 4) || $past(hdr_sel_a, 5)) else $error("data");
   latch_route_a: assert property (
      $rose(latch_clock_in) |-> $past(hdr_sel_b, 4) || $past(hdr_sel_b, 5)) else $error("latch");
   shift_route_a: assert property (
      $rose(shift_clock_in) |-> $past(hdr_sel_c, 4) || $past(hdr_sel_c, 5)) else $error("shift");
   lamp_follow_a: assert property (
      {indicator_lamp_4, indicator_lamp_3, indicator_lamp_2, indicator_lamp_1} ==
      {drive_input_4, drive_input_3, drive_input_2, drive_input_1}) else $error("lamp");
   phase_one_a: assert property (
      motor_a_phase_1 != drive_input_1) else $error("phase one");
   phase_rest_a: assert property (
      {motor_a_phase_4, motor_a_phase_3, motor_a_phase_2} ==
      ~{drive_input_4, drive_input_3, drive_input_2}) else $error("phases");
   phase_far_a: assert property (
      {motor_b_phase_4, motor_b_phase_3, motor_b_phase_2, motor_b_phase_1} ==
      ~{drive_input_8, drive_input_7, drive_input_6, drive_input_5}) else $error("far");
   err_pair_a: assert property (
      pslverr |-> pready) else $error("error alone");
endmodule // router_chk
bind stepper_channel_mode_router router_chk chk (.*);
`default_nettype wire

//--- test/stepper_channel_mode_router_test.sv
// self-checking bench for the channel mode router
`timescale 1ns/1ps
`default_nettype none
`include "router_defines.svh"
module stepper_channel_mode_router_test;
   logic clk = 1'b0, sys_rst = 1'b1, psel = 1'b0, penable = 1'b0, pwrite = 1'b0, er;
   logic [11:0] paddr = 12'h000;
   logic [31:0] pwdata = 32'h0, rd;
   wire [31:0] prdata;
   wire pready, pslverr, sdi, sck, lck, gate_n;
   wire [7:0] pins, d, ph;
   wire [3:0] lamp;
   int failures = 0, checks_done = 0, cyc = 0;
   host_gpio_model host (.clk(clk), .pins(pins));
   stepper_channel_mode_router dut (.clk(clk), .sys_rst(sys_rst), .psel(psel),
      .penable(penable), .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata),
      .pready(pready), .pslverr(pslverr), .hdr_sel_a(pins[0]), .hdr_sel_b(pins[1]),
      .hdr_sel_c(pins[2]), .hdr_aux_fourth(pins[3]), .hdr_aux_line_a(pins[4]),
      .hdr_aux_line_b(pins[5]), .hdr_aux_line_c(pins[6]), .hdr_aux_line_d(pins[7]),
      .shift_data_in(sdi), .shift_clock_in(sck), .latch_clock_in(lck), .output_gate_n(gate_n),
      .drive_input_1(d[0]), .drive_input_2(d[1]), .drive_input_3(d[2]), .drive_input_4(d[3]),
      .drive_input_5(d[4]), .drive_input_6(d[5]), .drive_input_7(d[6]), .drive_input_8(d[7]),
      .indicator_lamp_1(lamp[0]), .indicator_lamp_2(lamp[1]), .indicator_lamp_3(lamp[2]),
      .indicator_lamp_4(lamp[3]), .motor_a_phase_1(ph[0]), .motor_a_phase_2(ph[1]),
      .motor_a_phase_3(ph[2]), .motor_a_phase_4(ph[3]), .motor_b_phase_1(ph[4]),
      .motor_b_phase_2(ph[5]), .motor_b_phase_3(ph[6]), .motor_b_phase_4(ph[7]));
   initial forever #2 clk = ~clk;
   always @(posedge clk) if (++cyc > 20000) begin
      failures++;
      summarize();
   end
   task automatic chk(input logic [31:0] got, exp);
      checks_done++;
      if (got !== exp) begin
         failures++;
         $display("MISMATCH t=%0t got=%h exp=%h", $time, got, exp);
      end
   endtask
   // one apb transfer, released only after pready is seen
   task automatic apb(input logic w, input logic [11:0] a, input logic [31:0] v);
      psel <= 1'b1;
      penable <= 1'b0;
      pwrite <= w;
      paddr <= a;
      pwdata <= v;
      @(posedge clk);
      penable <= 1'b1;
      // if pready never comes, only the bench timeout ends this wait
      do @(posedge clk); while (pready !== 1'b1);
      rd = prdata;
      er = pslverr;
      psel <= 1'b0;
      penable <= 1'b0;
      @(posedge clk);
   endtask
   task automatic outs(input logic [7:0] e);
      chk({24'h0, d}, {24'h0, e});
      chk({28'h0, lamp}, {28'h0, e[3:0]});
      chk({24'h0, ph}, {24'h0, ~e});
      apb(1'b0, `STATUS_OFFSET, 32'h0);
      chk({24'h0, rd[7:0]}, {24'h0, e});
   endtask
   task automatic summarize;
      $display("checks %0d failures %0d", checks_done, failures);
      if (failures == 0 && checks_done > 0)
         $display("All tests passed");
      else
         $display("Some tests failed");
      $finish;
   endtask
   initial begin
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
      apb(1'b0, `CTRL_OFFSET, 32'h0);
      chk(rd, 32'h0000_0100);
      chk({31'h0, gate_n}, 32'h0);
      apb(1'b1, 12'h00C, 32'h0000_00FF);
      chk({31'h0, er}, 32'h1);
      host.send(8'hA5);
      outs(8'hA5);
      host.send(8'h3C);
      outs(8'h3C);
      // gate is written with the selectors but its flop lags them one cycle, so shift outputs fight host lines for that cycle
      apb(1'b1, `CTRL_OFFSET, 32'h0000_01FF);
      // the gate flop updates on the edge the task returns on
      @(posedge clk);
      chk({31'h0, gate_n}, 32'h1);
      foreach (rd[i]) if (i < 2) begin
         host.put(i ? 8'h4A : 8'hB5);
         outs(i ? 8'h4A : 8'hB5);
         chk({29'h0, sck, lck, sdi}, 32'h0);
      end
      apb(1'b1, `CTRL_OFFSET, 32'h0000_000F);
      host.put(8'hFF);
      outs(8'h07);
      apb(1'b0, `PINS_OFFSET, 32'h0);
      chk(rd, 32'h0000_00FF);
      // gate enabled beside a parallel line: host wins and contention is flagged
      apb(1'b1, `CTRL_OFFSET, 32'h0000_0101);
      repeat (4) @(posedge clk);
      outs(8'h3D);
      chk(rd, 32'h0178_3C3D);
      host.put(8'h00);
      sys_rst <= 1'b1;
      repeat (10) @(posedge clk);
      sys_rst <= 1'b0;
      repeat (2) @(posedge clk);
      apb(1'b0, `CTRL_OFFSET, 32'h0);
      chk(rd, 32'h0000_0100);
      outs(8'h00);
      summarize();
   end
endmodule // stepper_channel_mode_router_test
`default_nettype wire
